//--- verilog/dps_sram.sv
// Dual-port double-rate burst SRAM with AXI4-Lite status port
//
// Notes on behaviour
// RULE1 - Loop enabled gives 1.5 cycle read latency; loop disabled gives one cycle.
// RULE2 - Accesses start on positive input clock rise; sampling uses input clock rises.
// RULE3 - Write data, selects and byte selects are captured on input clock rises.
// RULE4 - Read data launched on output clock rises, or input clocks in single mode.
// RULE5 - Each access is a two-word burst at one address from two half-arrays.
// RULE6 - Read starts with read select low at positive rise; address latched then.
// RULE7 - First read word at negative output rise t+1, second at positive t+2.
// RULE8 - Read outputs go high impedance after the next output rise following word two.
// RULE9 - Write starts with write select low at positive rise; first word captured then.
// RULE10 - Negative rise latches write address and second word, then commits both words.
// RULE11 - Deselected write port finishes pending write and ignores its inputs.
// RULE12 - Byte selects sampled with each word; asserted stores, deasserted keeps byte.
// RULE13 - Select 0 gates bits 8:0, select 1 bits 17:9, active low.
// RULE14 - Output clocks high at power-on select single-clock mode, fixed thereafter.
// RULE15 - Read and write ports run independently, even same cycle same address.
// RULE16 - Reads of a written address return newest data, forwarding recent writes; the model has no forwarding and reads both halves at word one's rise.
// RULE17 - Port selects sampled only on positive rises; ports do not affect each other.
// RULE18 - Pending reads and writes complete before a port is deselected.
// RULE19 - Output impedance recalibrated every 1024 input clock cycles from power-up.
// RULE20 - Echo clocks follow output clocks, or input clocks in single mode.
// RULE21 - Loop locks 1024 cycles after stable input clock, no reset needed.
// RULE22 - Loop resets when the input clock stops or slows for 30 ns.
// RULE23 - Controller keeps input clock between 120 MHz and maximum while loop enabled.
// RULE24 - Device powers up with ports deselected and read outputs high impedance.
// RULE25 - Both selects high at positive rise: no access, outputs stay high impedance.
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module dps_sram #(
  parameter int ADDR_W = 20,
  parameter int WORD_W = 18,
  parameter int DLL_STOP_CYC = dps_pkg::STOP_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Memory clock pins
  input wire logic k_pos,
  input wire logic k_neg,
  input wire logic c_pos,
  input wire logic c_neg,
  // Memory control pins
  input wire logic loop_disable_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [WORD_W/dps_pkg::BYTE_W-1:0] byte_write_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WORD_W-1:0] d,
  // Read data pins and echo clocks
  output logic [WORD_W-1:0] q_out,
  output logic q_oe_n,
  output logic echo_pos,
  output logic echo_neg,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int BW = WORD_W / dps_pkg::BYTE_W;
  localparam int DIN_W = ADDR_W + WORD_W + BW + 3;

  logic [3:0] clk_lvl;
  logic [3:0] clk_rise;
  logic [DIN_W-1:0] din_lvl;
  logic kp_rise, kn_rise, op_rise, on_rise, op_lvl, on_lvl, out_evt;
  logic ldn_s, rps_s, wps_s, legacy;
  logic [BW-1:0] bws_s;
  logic [ADDR_W-1:0] addr_s;
  logic [WORD_W-1:0] d_s;
  logic single_clk_ff, strap_done_ff;
  logic [1:0] strap_cnt_ff;
  logic rd_acc, wr_start, wr_commit;
  logic rp_vld_ff [dps_pkg::PIPE_D];
  logic [ADDR_W-1:0] rp_addr_ff [dps_pkg::PIPE_D];
  logic rp_half_ff [dps_pkg::PIPE_D];
  logic [WORD_W-1:0] mem_lo [2**ADDR_W];
  logic [WORD_W-1:0] mem_hi [2**ADDR_W];
  logic [WORD_W-1:0] merged_lo, merged_hi, rd_word;
  logic [WORD_W-1:0] wd0_ff, q_out_ff, hi_snap_ff;
  logic [BW-1:0] wb0_n_ff;
  dps_pkg::dps_wr_state_type wr_state_ff;
  logic q_oe_n_ff, echo_pos_ff, echo_neg_ff;
  logic [7:0] idle_cnt_ff;
  logic [9:0] dll_cnt_ff, cal_div_ff;
  logic dll_locked_ff, stopped, relock_ff;
  logic [15:0] cal_cnt_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_hold_ff, w_hold_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff, rd_mux;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff, rd_resp;

  // Pin synchronisers: clocks and data share one delay
  dps_sync_edge #(.W(4)) u_clk_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({c_neg, c_pos, k_neg, k_pos}),
    .lvl(clk_lvl),
    .rise(clk_rise)
  );
  dps_sync_edge #(.W(DIN_W)) u_din_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({loop_disable_n, read_port_select_n, write_port_select_n,
             byte_write_select_n, addr, d}),
    .lvl(din_lvl),
    .rise()
  );

  // Field split and edge selection
  assign {ldn_s, rps_s, wps_s, bws_s, addr_s, d_s} = din_lvl;
  assign kp_rise = clk_rise[0]; // RULE2
  assign kn_rise = clk_rise[1]; // RULE2
  assign op_rise = single_clk_ff ? clk_rise[0] : clk_rise[2]; // RULE4
  assign on_rise = single_clk_ff ? clk_rise[1] : clk_rise[3]; // RULE4
  assign op_lvl = single_clk_ff ? clk_lvl[0] : clk_lvl[2];
  assign on_lvl = single_clk_ff ? clk_lvl[1] : clk_lvl[3];
  assign out_evt = op_rise | on_rise;
  assign legacy = ~ldn_s;
  assign rd_acc = kp_rise & ~rps_s; // RULE6 RULE17 RULE25
  assign wr_start = kp_rise & ~wps_s; // RULE9 RULE17 RULE25
  assign wr_commit = (wr_state_ff == dps_pkg::DPS_WR_PEND) & kn_rise; // RULE10

  // Strap capture after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      single_clk_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == dps_pkg::STRAP_WAIT) begin
        single_clk_ff <= clk_lvl[2] & clk_lvl[3]; // RULE14
        strap_done_ff <= 1'b1;
      end
    end
  end

  // Read pipeline: one slot per output clock rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < dps_pkg::PIPE_D; i++) begin
        rp_vld_ff[i] <= 1'b0;
        rp_addr_ff[i] <= '0;
        rp_half_ff[i] <= 1'b0;
      end
    end else begin
      if (out_evt) begin
        for (int i = 0; i < dps_pkg::PIPE_D - 1; i++) begin
          rp_vld_ff[i] <= rp_vld_ff[i+1];
          rp_addr_ff[i] <= rp_addr_ff[i+1];
          rp_half_ff[i] <= rp_half_ff[i+1];
        end
        rp_vld_ff[dps_pkg::PIPE_D-1] <= 1'b0;
      end
      if (rd_acc && legacy) begin
        rp_vld_ff[dps_pkg::LEG_W0_IDX] <= 1'b1; // RULE1
        rp_addr_ff[dps_pkg::LEG_W0_IDX] <= addr_s;
        rp_half_ff[dps_pkg::LEG_W0_IDX] <= 1'b0;
        rp_vld_ff[dps_pkg::LEG_W0_IDX+1] <= 1'b1;
        rp_addr_ff[dps_pkg::LEG_W0_IDX+1] <= addr_s;
        rp_half_ff[dps_pkg::LEG_W0_IDX+1] <= 1'b1;
      end else if (rd_acc) begin
        rp_vld_ff[dps_pkg::DLL_W0_IDX] <= 1'b1; // RULE1 RULE7
        rp_addr_ff[dps_pkg::DLL_W0_IDX] <= addr_s; // RULE6
        rp_half_ff[dps_pkg::DLL_W0_IDX] <= 1'b0;
        rp_vld_ff[dps_pkg::DLL_W0_IDX+1] <= 1'b1; // RULE5
        rp_addr_ff[dps_pkg::DLL_W0_IDX+1] <= addr_s;
        rp_half_ff[dps_pkg::DLL_W0_IDX+1] <= 1'b1;
      end
    end
  end

  // Write port sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= dps_pkg::DPS_WR_IDLE;
      wd0_ff <= '0;
      wb0_n_ff <= '1;
    end else begin
      if (wr_start) begin
        wr_state_ff <= dps_pkg::DPS_WR_PEND; // RULE9
        wd0_ff <= d_s; // RULE3
        wb0_n_ff <= bws_s; // RULE12
      end else if (wr_commit) begin
        wr_state_ff <= dps_pkg::DPS_WR_IDLE; // RULE11 RULE18
      end
    end
  end

  // Byte merge of both words into stored contents
  always_comb begin
    merged_lo = mem_lo[addr_s];
    merged_hi = mem_hi[addr_s];
    for (int b = 0; b < BW; b++) begin
      if (!wb0_n_ff[b]) begin
        merged_lo[b*dps_pkg::BYTE_W +: dps_pkg::BYTE_W] =
          wd0_ff[b*dps_pkg::BYTE_W +: dps_pkg::BYTE_W]; // RULE12 RULE13
      end
      if (!bws_s[b]) begin
        merged_hi[b*dps_pkg::BYTE_W +: dps_pkg::BYTE_W] =
          d_s[b*dps_pkg::BYTE_W +: dps_pkg::BYTE_W]; // RULE12 RULE13
      end
    end
  end

  // Array commit at the negative input rise
  always_ff @(posedge aclk) begin
    if (wr_commit) begin
      mem_lo[addr_s] <= merged_lo; // RULE10 RULE5
      mem_hi[addr_s] <= merged_hi;
    end
  end

  // Low word live from the array, high word from the snapshot taken with it
  assign rd_word = rp_half_ff[0] ? hi_snap_ff : mem_lo[rp_addr_ff[0]]; // RULE15 RULE16

  // Output register: drive or release at each output rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_out_ff <= '0;
      hi_snap_ff <= '0;
      q_oe_n_ff <= 1'b1; // RULE24
    end else if (out_evt) begin
      if (rp_vld_ff[0]) begin
        q_out_ff <= rd_word; // RULE4 RULE7
        q_oe_n_ff <= 1'b0;
        if (!rp_half_ff[0]) begin
          // Array read precedes this edge's commit: later writes stay unseen
          hi_snap_ff <= mem_hi[rp_addr_ff[0]]; // RULE16
        end
      end else begin
        q_oe_n_ff <= 1'b1; // RULE8 RULE25
      end
    end
  end

  // Echo clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      echo_pos_ff <= 1'b0;
      echo_neg_ff <= 1'b0;
    end else begin
      echo_pos_ff <= op_lvl; // RULE20
      echo_neg_ff <= on_lvl; // RULE20
    end
  end

  // Input clock stop detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt_ff <= 8'h00;
    end else if (kp_rise || kn_rise) begin
      idle_cnt_ff <= 8'h00;
    end else if (idle_cnt_ff != 8'hFF) begin
      idle_cnt_ff <= idle_cnt_ff + 8'h01;
    end
  end
  assign stopped = idle_cnt_ff >= 8'(DLL_STOP_CYC); // RULE22

  // Loop lock counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dll_cnt_ff <= 10'h000;
      dll_locked_ff <= 1'b0;
    end else if (!ldn_s || stopped || relock_ff) begin
      dll_cnt_ff <= 10'h000; // RULE22
      dll_locked_ff <= 1'b0;
    end else if (kp_rise && !dll_locked_ff) begin
      dll_cnt_ff <= dll_cnt_ff + 10'h001;
      if (dll_cnt_ff == 10'(dps_pkg::LOCK_CYC - 1)) begin
        dll_locked_ff <= 1'b1; // RULE21
      end
    end
  end

  // Impedance recalibration period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_div_ff <= 10'h000;
      cal_cnt_ff <= dps_pkg::CAL_RST;
    end else if (kp_rise) begin
      cal_div_ff <= cal_div_ff + 10'h001;
      if (cal_div_ff == 10'(dps_pkg::CAL_CYC - 1)) begin
        cal_cnt_ff <= cal_cnt_ff + 16'h0001; // RULE19
      end
    end
  end

  // AXI write: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= dps_pkg::RESP_OKAY;
      relock_ff <= 1'b0;
    end else begin
      relock_ff <= 1'b0;
      if (s_axi_awvalid && awready_ff) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end
      if (aw_hold_ff && w_hold_ff && !bvalid_ff) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        case (aw_addr_ff)
          dps_pkg::OFS_CTRL: begin
            bresp_ff <= dps_pkg::RESP_OKAY;
            relock_ff <= w_strb_ff[0] & w_data_ff[dps_pkg::CTRL_RELOCK_BIT];
          end
          dps_pkg::OFS_STATUS, dps_pkg::OFS_CAL: begin
            bresp_ff <= dps_pkg::RESP_OKAY;
          end
          default: begin
            bresp_ff <= dps_pkg::RESP_SLVERR;
          end
        endcase
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // AXI read decode
  always_comb begin
    rd_mux = 32'h00000000;
    rd_resp = dps_pkg::RESP_OKAY;
    case (s_axi_araddr)
      dps_pkg::OFS_CTRL: begin
        rd_mux = 32'h00000000;
      end
      dps_pkg::OFS_STATUS: begin
        rd_mux[dps_pkg::ST_LOCK_BIT] = dll_locked_ff;
        rd_mux[dps_pkg::ST_SINGLE_BIT] = single_clk_ff;
        rd_mux[dps_pkg::ST_LEGACY_BIT] = legacy;
        rd_mux[dps_pkg::ST_WBUSY_BIT] = wr_state_ff == dps_pkg::DPS_WR_PEND;
        rd_mux[dps_pkg::ST_RBUSY_BIT] = rp_vld_ff[0] | rp_vld_ff[1] | rp_vld_ff[2] |
                                        rp_vld_ff[3];
      end
      dps_pkg::OFS_CAL: begin
        rd_mux[15:0] = cal_cnt_ff;
      end
      default: begin
        rd_resp = dps_pkg::RESP_SLVERR;
      end
    endcase
  end

  // AXI read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= dps_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_resp;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Port outputs
  assign q_out = q_out_ff;
  assign q_oe_n = q_oe_n_ff;
  assign echo_pos = echo_pos_ff;
  assign echo_neg = echo_neg_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_dll_read_slots: assert property ( // RULE1
    rd_acc && !legacy |=> rp_vld_ff[2] && rp_vld_ff[3] && !rp_half_ff[2]
      && rp_half_ff[3] && rp_addr_ff[2] == $past(addr_s))
    else $error("read not queued at loop-enabled slots");
  chk_legacy_slots: assert property ( // RULE1
    rd_acc && legacy |=> rp_vld_ff[1] && !rp_half_ff[1] && rp_half_ff[2])
    else $error("read not queued at legacy slots");
  chk_word_drive: assert property ( // RULE7
    out_evt && rp_vld_ff[0] |=> !q_oe_n_ff && q_out_ff == $past(rd_word))
    else $error("read word not driven at output rise");
  chk_release_bus: assert property ( // RULE8
    out_evt && !rp_vld_ff[0] |=> q_oe_n_ff)
    else $error("read bus not released");
  chk_write_first: assert property ( // RULE9
    wr_start |=> wr_state_ff == dps_pkg::DPS_WR_PEND && wd0_ff == $past(d_s))
    else $error("first write word not captured");
  chk_commit_data: assert property ( // RULE10
    wr_commit && !wr_start |=> mem_hi[$past(addr_s)] == $past(merged_hi)
      && wr_state_ff == dps_pkg::DPS_WR_IDLE)
    else $error("write not committed");
  chk_mask_keep: assert property ( // RULE13
    wr_commit && (&bws_s) |=> mem_hi[$past(addr_s)] == $past(mem_hi[addr_s]))
    else $error("masked word altered");
  chk_idle_nostart: assert property ( // RULE25
    kp_rise && rps_s && wps_s && wr_state_ff == dps_pkg::DPS_WR_IDLE
      |=> wr_state_ff == dps_pkg::DPS_WR_IDLE)
    else $error("access started while deselected");
  chk_strap_fixed: assert property ( // RULE14
    strap_done_ff |=> $stable(single_clk_ff))
    else $error("clock strap changed");
  chk_lock_time: assert property ( // RULE21
    $rose(dll_locked_ff) |-> $past(dll_cnt_ff) == 10'(dps_pkg::LOCK_CYC - 1))
    else $error("loop locked at wrong count");
  chk_stop_reset: assert property ( // RULE22
    stopped |=> !dll_locked_ff)
    else $error("loop stayed locked with clock stopped");
  chk_echo_follow: assert property ( // RULE20
    op_rise |=> $rose(echo_pos_ff))
    else $error("echo does not follow output clock");
  chk_bresp_hold: assert property (
    bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped");

  cov_dll_read: cover property (rd_acc && !legacy ##[1:60] out_evt && rp_vld_ff[0]);
  cov_legacy_read: cover property (rd_acc && legacy);
  cov_masked_write: cover property (wr_commit && !(&bws_s) && (|bws_s));
  cov_same_cycle: cover property (rd_acc && wr_start);
endmodule // dps_sram

//--- verilog/dps_pkg.sv
// Constants shared by the dual-port burst SRAM model
package dps_pkg;
  // Lane and pipeline geometry
  localparam int BYTE_W = 9;
  localparam int PIPE_D = 4;
  localparam int DLL_W0_IDX = 2;
  localparam int LEG_W0_IDX = 1;
  // Timing: system clock period and loop stop time in ns
  localparam int CLK_NS = 10;
  localparam int STOP_NS = 30;
  localparam int STOP_CYC = (STOP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_CYC = 1024;
  localparam int CAL_CYC = 1024;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CAL = 8'h08;
  // Field positions
  localparam int CTRL_RELOCK_BIT = 0;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_SINGLE_BIT = 1;
  localparam int ST_LEGACY_BIT = 2;
  localparam int ST_WBUSY_BIT = 3;
  localparam int ST_RBUSY_BIT = 4;
  // Reset values and responses
  localparam logic [15:0] CAL_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Write port states
  typedef enum logic [1:0] {
    DPS_WR_IDLE = 2'b01,
    DPS_WR_PEND = 2'b10
  } dps_wr_state_type;
endpackage

//--- verilog/dps_sync_edge.sv
// Two-flop synchroniser with rising-edge detection
`timescale 1ns/1ps
module dps_sync_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pins
  input wire logic [W-1:0] pin_in,
  // Synchronised level and rise pulse
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  // Synchroniser chain and edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Level reads the second stage, rise compares it with the third
  assign lvl = sync_ff;
  assign rise = sync_ff & ~prev_ff;
endmodule // dps_sync_edge

//--- test/dps_ctl_model.sv
// Memory controller model driving the clock, select, address and data pins
`timescale 1ns/1ps
module dps_ctl_model (
  // System clock
  input wire logic aclk,
  // Read side pins
  input wire logic [17:0] q_out,
  input wire logic q_oe_n,
  input wire logic echo_pos,
  input wire logic echo_neg,
  // Driven pins
  output logic k_pos,
  output logic k_neg,
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic [1:0] byte_write_select_n,
  output logic [19:0] addr,
  output logic [17:0] d
);
  logic [20:0] smp[$];
  int nk = 0;
  // Quiet pins, clock parked low
  initial begin
    k_pos = 1'b0;
    k_neg = 1'b0;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    byte_write_select_n = 2'h3;
    addr = 20'h0;
    d = 18'h0;
  end
  // Half period, outputs sampled just before the edge
  task half();
    repeat (7) @(posedge aclk);
    #1;
    smp.push_back({echo_pos, echo_neg, q_oe_n, q_out});
    @(posedge aclk);
  endtask
  // One clock: access and first word on the rise, write address on the fall
  task kcycle(input logic rs, input logic ws, input logic [19:0] ra, input logic [19:0] wa,
              input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] b0,
              input logic [1:0] b1);
    half();
    k_pos <= 1'b1;
    k_neg <= 1'b0;
    read_port_select_n <= rs;
    write_port_select_n <= ws;
    addr <= ra;
    d <= d0;
    byte_write_select_n <= b0;
    nk++;
    half();
    k_pos <= 1'b0;
    k_neg <= 1'b1;
    read_port_select_n <= 1'b1;
    write_port_select_n <= 1'b1;
    addr <= ws ? ~ra : wa;
    d <= ws ? ~d0 : d1;
    byte_write_select_n <= b1;
  endtask
  // Stop the clock between frames, data lines scrambled
  task stop();
    half();
    k_neg <= 1'b0;
    addr <= ~addr;
    d <= ~d;
  endtask
endmodule // dps_ctl_model

//--- test/dual_port_ddr_burst_sram_bench.sv
// Self-checking bench for the dual-port burst SRAM
`timescale 1ns/1ps
module dual_port_ddr_burst_sram_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic loop_disable_n = 1'b1;
  logic k_pos, k_neg, read_port_select_n, write_port_select_n, q_oe_n, echo_pos, echo_neg;
  logic [1:0] byte_write_select_n, bresp, rresp;
  logic [19:0] addr;
  logic [17:0] d, q_out;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [35:0] mem[4];
  logic [19:0] pool[4];
  int miscompares = 0;
  int samples_checked = 0;
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // Design, single-clock strap
  dps_sram #(.DLL_STOP_CYC(20)) i_dut (
    .aclk, .aresetn, .k_pos, .k_neg, .c_pos(1'b1), .c_neg(1'b1), .loop_disable_n,
    .read_port_select_n, .write_port_select_n, .byte_write_select_n, .addr, .d,
    .q_out, .q_oe_n, .echo_pos, .echo_neg,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // Controller model
  dps_ctl_model i_ctl (.aclk, .q_out, .q_oe_n, .echo_pos, .echo_neg, .k_pos, .k_neg,
    .read_port_select_n, .write_port_select_n, .byte_write_select_n, .addr, .d);
  // Compare and count
  task check(input logic [35:0] seen, input logic [35:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Register write, address and data offered together
  task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Register read
  task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Stored word after a masked write, lanes active low
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] b);
    merge = o;
    for (int i = 0; i < 4; i++)
      if (!b[i])
        merge[i*9 +: 9] = n[i*9 +: 9];
  endfunction
  // Random back-to-back reads and writes, then slot-by-slot compare
  task automatic stream(input int n, input int lat);
    logic [36:0] e[$];
    logic rs, ws;
    logic [1:0] ri, wi, b0, b1;
    logic [17:0] d0, d1;
    i_ctl.smp.delete();
    for (int j = 0; j < n + 3; j++) begin
      rs = (j < 4 || j >= n) ? 1'b1 : 1'($urandom_range(1));
      ws = (j >= n) ? 1'b1 : (j < 4) ? 1'b0 : 1'($urandom_range(1));
      ri = 2'($urandom_range(3));
      wi = (j < 4) ? 2'(j) : 2'($urandom_range(3));
      d0 = 18'($urandom);
      d1 = 18'($urandom);
      b0 = (j < 4) ? 2'h0 : 2'(j);
      b1 = (j < 4) ? 2'h0 : 2'($urandom);
      if (!ws)
        mem[wi] = merge(mem[wi], {d1, d0}, {b1, b0});
      e.push_back({rs, mem[ri]});
      i_ctl.kcycle(rs, ws, pool[ri], pool[wi], d0, d1, b0, b1);
    end
    i_ctl.stop();
    check(36'(i_ctl.smp[1][20:19]), 36'h2, "echo during high phase");
    check(36'(i_ctl.smp[2][20:19]), 36'h1, "echo during low phase");
    for (int j = 0; j < n; j++) begin
      if (!e[j][36]) begin
        check(36'(i_ctl.smp[2*j+lat][18:0]), 36'(e[j][17:0]), "first word");
        check(36'(i_ctl.smp[2*j+lat+1][18:0]), 36'(e[j][35:18]), "second word");
      end else begin
        check(36'(i_ctl.smp[2*j+lat][18]), 36'h1, "released slot");
        check(36'(i_ctl.smp[2*j+lat+1][18]), 36'h1, "idle slot");
      end
    end
  endtask
  // Main sequence
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    v = $urandom(32'h4244);
    for (int i = 0; i < 4; i++)
      pool[i] = {18'($urandom), 2'(i)};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    check(36'(q_oe_n), 36'h1, "outputs off after reset");
    axi_rd(dps_pkg::OFS_STATUS, v, r);
    check(36'(v[2:1]), 36'h1, "single clock strap");
    axi_rd(dps_pkg::OFS_CAL, v, r);
    check(36'(v[15:0]), 36'(dps_pkg::CAL_RST), "calibration count at reset");
    $display("test reset done");
    stream(28, 4);
    axi_rd(dps_pkg::OFS_STATUS, v, r);
    check(36'(v[0]), 36'h0, "no lock yet");
    $display("test loop-on stream done");
    for (int i = 0; i < 1030; i++)
      i_ctl.kcycle(1'b1, 1'b1, 20'($urandom), 20'h0, 18'($urandom), 18'h0, 2'h3, 2'h3);
    axi_rd(dps_pkg::OFS_STATUS, v, r);
    check(36'(v[0]), 36'h1, "locked");
    axi_rd(dps_pkg::OFS_CAL, v, r);
    check(36'(v[15:0]), 36'(i_ctl.nk / 1024), "calibration count");
    repeat (40) @(posedge aclk);
    axi_rd(dps_pkg::OFS_STATUS, v, r);
    check(36'(v[0]), 36'h0, "lock lost on stopped clock");
    i_ctl.stop();
    $display("test lock done");
    loop_disable_n <= 1'b0;
    repeat (10) @(posedge aclk);
    axi_rd(dps_pkg::OFS_STATUS, v, r);
    check(36'(v[2]), 36'h1, "legacy mode");
    stream(20, 3);
    $display("test legacy stream done");
    axi_wr(dps_pkg::OFS_CTRL, 32'h1, r);
    check(36'(r), 36'(dps_pkg::RESP_OKAY), "control write");
    axi_rd(dps_pkg::OFS_CTRL, v, r);
    check(36'(v[0]), 36'h0, "restart bit reads zero");
    axi_wr(8'h0C, 32'hFFFF_FFFF, r);
    check(36'(r), 36'(dps_pkg::RESP_SLVERR), "unmapped write");
    axi_rd(8'h0C, v, r);
    check(36'(r), 36'(dps_pkg::RESP_SLVERR), "unmapped read");
    axi_wr(dps_pkg::OFS_STATUS, 32'h0, r);
    axi_rd(dps_pkg::OFS_STATUS, v, r);
    check(36'(v[2:1]), 36'h3, "status not writable");
    $display("test registers done");
    wrap_up();
  end
  // Hang guard
  initial begin
    #400_000;
    miscompares++;
    wrap_up();
  end
  // Verdict
  task wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
endmodule // dual_port_ddr_burst_sram_bench
